// ===== fpc_defs.vh
`ifndef FPC_DEFS_VH
`define FPC_DEFS_VH
// ***************************************************************
// register map of the controller (axi4-lite byte addresses)
// ***************************************************************
`define FPC_REG_CTRL 8'h00
`define FPC_REG_ADDR 8'h04
`define FPC_REG_WDATA 8'h08
`define FPC_REG_PWLO 8'h0c
`define FPC_REG_PWHI 8'h10
`define FPC_REG_STATUS 8'h14
`define FPC_REG_RDATA 8'h18
`define FPC_REG_PWRLO 8'h1c
`define FPC_REG_PWRHI 8'h20
// ctrl fields
`define FPC_CTRL_GO 0
`define FPC_CTRL_WIDE 1
`define FPC_CTRL_OP_LO 4
`define FPC_CTRL_OP_HI 7
`define FPC_CTRL_SET_LO 8
`define FPC_CTRL_SET_HI 15
// operation codes
`define FPC_OP_ENTER 4'h0
`define FPC_OP_EXIT 4'h1
`define FPC_OP_PROG_BIT 4'h2
`define FPC_OP_READ_ST 4'h3
`define FPC_OP_PW_READ 4'h4
`define FPC_OP_PW_UNLOCK 4'h5
`define FPC_OP_CLEAR_ALL 4'h6
`define FPC_OP_EXT_EXIT 4'h7
`define FPC_OP_EXT_PROG 4'h8
`define FPC_OP_RAW_READ 4'h9
`define FPC_OP_RAW_WRITE 4'ha
`define FPC_OP_PW_PROG 4'hb
// command bytes
`define FPC_D_UNLOCK1 8'haa
`define FPC_D_UNLOCK2 8'h55
`define FPC_D_PROG 8'ha0
`define FPC_D_EXIT1 8'h90
`define FPC_D_EXIT2 8'h00
`define FPC_D_PW1 8'h25
`define FPC_D_PW2 8'h03
`define FPC_D_PW_END 8'h29
`define FPC_D_CLR1 8'h80
`define FPC_D_CLR2 8'h30
// unlock addresses
`define FPC_A8_FIRST 24'h000aaa
`define FPC_A8_SECOND 24'h000555
`define FPC_A16_FIRST 24'h000555
`define FPC_A16_SECOND 24'h0002aa
// bus timing in clock cycles; password attempt gap in ns and in cycles
`define FPC_T_STROBE 8'h08
`define FPC_T_GAP 8'h04
`define FPC_PW_GAP_NS 6000
`define FPC_PW_GAP_CYC ((`FPC_PW_GAP_NS + 3) / 4)
`endif

// ===== fpc_flash_cycle.v
`timescale 1ns/1ps
`include "fpc_defs.vh"
// ***************************************************************
// one asynchronous flash bus cycle, read or write
// ***************************************************************
module fpc_flash_cycle (
	input wire aclk,
	input wire aresetn,
	input wire start,
	input wire is_read,
	input wire [23:0] addr,
	input wire [15:0] wdata,
	input wire [15:0] dq_in,
	output reg done_ff,
	output reg [15:0] rdata_ff,
	output reg [23:0] fl_addr_ff,
	output reg [15:0] dq_out_ff,
	output reg dq_oe_n_ff,
	output reg ce_n_ff,
	output reg oe_n_ff,
	output reg we_n_ff
);
	localparam ST_IDLE = 2'd0;
	localparam ST_STROBE = 2'd1;
	localparam ST_GAP = 2'd2;
	reg [1:0] state_ff;
	reg [7:0] cnt_ff;
	reg rd_ff;
	always @(posedge aclk) begin
		if (!aresetn) begin
			state_ff <= ST_IDLE;
			cnt_ff <= 8'h00;
			rd_ff <= 1'b0;
			done_ff <= 1'b0;
			rdata_ff <= 16'h0000;
			fl_addr_ff <= 24'h000000;
			dq_out_ff <= 16'h0000;
			dq_oe_n_ff <= 1'b1;
			ce_n_ff <= 1'b1;
			oe_n_ff <= 1'b1;
			we_n_ff <= 1'b1;
		end else begin
			done_ff <= 1'b0;
			case (state_ff)
			ST_IDLE: begin
				if (start) begin
					rd_ff <= is_read;
					fl_addr_ff <= addr;
					dq_out_ff <= wdata;
					dq_oe_n_ff <= is_read;
					ce_n_ff <= 1'b0;
					oe_n_ff <= ~is_read;
					we_n_ff <= is_read;
					cnt_ff <= `FPC_T_STROBE;
					state_ff <= ST_STROBE;
				end
			end
			ST_STROBE: begin
				if (cnt_ff == 8'h01) begin
					// data latched on the rising strobe edge
					if (rd_ff)
						rdata_ff <= dq_in;
					ce_n_ff <= 1'b1;
					oe_n_ff <= 1'b1;
					we_n_ff <= 1'b1;
					cnt_ff <= `FPC_T_GAP;
					state_ff <= ST_GAP;
				end else begin
					cnt_ff <= cnt_ff - 8'h01;
				end
			end
			ST_GAP: begin
				// keep data driven through the hold gap
				if (cnt_ff == 8'h01) begin
					dq_oe_n_ff <= 1'b1;
					done_ff <= 1'b1;
					state_ff <= ST_IDLE;
				end else begin
					cnt_ff <= cnt_ff - 8'h01;
				end
			end
			default: state_ff <= ST_IDLE;
			endcase
		end
	end
endmodule

// ===== fpc_ctrl.v
`timescale 1ns/1ps
`include "fpc_defs.vh"
// Notes on behaviour
// - enter a command set with AA, 55, set code at width-specific addresses.
// - exit a set with 90 then 00 at any address.
// - register, status and password reads are plain reads without command code.
// - status and password reads use bus read cycles, never writes.
// - each password program moves exactly one portion; a password read moves all four (x16) or eight (x8).
// - x8 password read is eight reads at 00..07, byte n at n.
// - x8 unlock: 25,03 at 00, eight bytes at 00..07, 29 at 00.
// - x16 unlock: 25,03 at 00, four words at 00..03, 29 at 00.
// - bit setting is A0 then 00 protect or 01 unprotect.
// - successive unlock attempts are spaced at least 6 us apart.
module fpc_ctrl (
	input wire aclk,
	input wire aresetn,
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	output wire [23:0] fl_addr,
	input wire [15:0] fl_dq_in,
	output wire [15:0] fl_dq_out,
	output wire fl_dq_oe_n,
	output wire fl_ce_n,
	output wire fl_oe_n,
	output wire fl_we_n
);
	// ***************************************************************
	// software registers
	// ***************************************************************
	reg [31:0] ctrl_ff;
	reg [23:0] addr_ff;
	reg [15:0] wdata_ff;
	reg [63:0] pw_ff;
	reg [63:0] pw_rd_ff;
	reg [15:0] rdata_ff;
	reg busy_ff;
	reg done_flag_ff;
	reg refused_ff;
	reg [31:0] pw_gap_ff;
	reg aw_held_ff;
	reg w_held_ff;
	reg [7:0] aw_addr_ff;
	reg [31:0] w_data_ff;
	reg [3:0] w_strb_ff;
	wire [3:0] op = ctrl_ff[`FPC_CTRL_OP_HI:`FPC_CTRL_OP_LO];
	wire wide = ctrl_ff[`FPC_CTRL_WIDE];
	wire [7:0] set_code = ctrl_ff[`FPC_CTRL_SET_HI:`FPC_CTRL_SET_LO];
	wire do_write = aw_held_ff && w_held_ff && !s_axi_bvalid;
	wire start_req;
	wire [31:0] wmask = {{8{w_strb_ff[3]}}, {8{w_strb_ff[2]}}, {8{w_strb_ff[1]}},
		{8{w_strb_ff[0]}}};
	wire pw_wait = (pw_gap_ff != 32'h00000000);
	wire finish;
	reg [4:0] step_ff;
	// ***************************************************************
	// axi4-lite slave: address and data taken in either order
	// ***************************************************************
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'b00;
			aw_held_ff <= 1'b0;
			w_held_ff <= 1'b0;
			aw_addr_ff <= 8'h00;
			w_data_ff <= 32'h00000000;
			w_strb_ff <= 4'h0;
			ctrl_ff <= 32'h00000000;
			addr_ff <= 24'h000000;
			wdata_ff <= 16'h0000;
			pw_ff <= {64{1'b1}};
		end else begin
			s_axi_awready <= !aw_held_ff && !s_axi_awready && s_axi_awvalid;
			s_axi_wready <= !w_held_ff && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_ff <= 1'b1;
				aw_addr_ff <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_ff <= 1'b1;
				w_data_ff <= s_axi_wdata;
				w_strb_ff <= s_axi_wstrb;
			end
			if (start_req)
				ctrl_ff[`FPC_CTRL_GO] <= 1'b0;
			if (do_write) begin
				aw_held_ff <= 1'b0;
				w_held_ff <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= 2'b00;
				case (aw_addr_ff)
				`FPC_REG_CTRL: begin
					// writes while busy are refused with slverr
					if (busy_ff)
						s_axi_bresp <= 2'b10;
					else
						ctrl_ff <= (ctrl_ff & ~wmask) | (w_data_ff & wmask);
				end
				`FPC_REG_ADDR: addr_ff <= (addr_ff & ~wmask[23:0]) | (w_data_ff[23:0] & wmask[23:0]);
				`FPC_REG_WDATA: wdata_ff <= (wdata_ff & ~wmask[15:0]) | (w_data_ff[15:0] & wmask[15:0]);
				`FPC_REG_PWLO: pw_ff[31:0] <= (pw_ff[31:0] & ~wmask) | (w_data_ff & wmask);
				`FPC_REG_PWHI: pw_ff[63:32] <= (pw_ff[63:32] & ~wmask) | (w_data_ff & wmask);
				default: s_axi_bresp <= 2'b10;
				endcase
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= 2'b00;
		end else begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= 2'b00;
				case (s_axi_araddr)
				`FPC_REG_CTRL: s_axi_rdata <= ctrl_ff;
				`FPC_REG_ADDR: s_axi_rdata <= {8'h00, addr_ff};
				`FPC_REG_WDATA: s_axi_rdata <= {16'h0000, wdata_ff};
				`FPC_REG_PWLO: s_axi_rdata <= pw_ff[31:0];
				`FPC_REG_PWHI: s_axi_rdata <= pw_ff[63:32];
				`FPC_REG_STATUS: s_axi_rdata <= {29'h00000000, refused_ff, done_flag_ff, busy_ff};
				`FPC_REG_RDATA: s_axi_rdata <= {16'h0000, rdata_ff};
				`FPC_REG_PWRLO: s_axi_rdata <= pw_rd_ff[31:0];
				`FPC_REG_PWRHI: s_axi_rdata <= pw_rd_ff[63:32];
				default: begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= 2'b10;
				end
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
	// ***************************************************************
	// command sequencer
	// ***************************************************************
	reg cyc_start_ff;
	reg cyc_read_ff;
	reg [23:0] cyc_addr_ff;
	reg [15:0] cyc_data_ff;
	reg [4:0] last_step_ff;
	reg waiting_ff;
	wire cyc_done;
	wire [15:0] cyc_rdata;
	wire [23:0] a_first = wide ? `FPC_A16_FIRST : `FPC_A8_FIRST;
	wire [23:0] a_second = wide ? `FPC_A16_SECOND : `FPC_A8_SECOND;
	wire [3:0] pw_count = wide ? 4'h4 : 4'h8;
	assign start_req = ctrl_ff[`FPC_CTRL_GO] && !busy_ff;
	assign finish = waiting_ff && cyc_done && (step_ff == last_step_ff);
	reg nxt_read;
	reg [23:0] nxt_addr;
	reg [15:0] nxt_data;
	reg [4:0] nxt_last;
	reg [3:0] pidx;
	// cycle table: step_ff selects one bus cycle of the current op
	always @* begin
		nxt_read = 1'b0;
		nxt_addr = 24'h000000;
		nxt_data = 16'h0000;
		nxt_last = 5'd0;
		pidx = step_ff[3:0] - 4'h2;
		case (op)
		`FPC_OP_ENTER: begin
			nxt_last = 5'd2;
			case (step_ff)
			5'd0: begin nxt_addr = a_first; nxt_data = {8'h00, `FPC_D_UNLOCK1}; end
			5'd1: begin nxt_addr = a_second; nxt_data = {8'h00, `FPC_D_UNLOCK2}; end
			default: begin nxt_addr = a_first; nxt_data = {8'h00, set_code}; end
			endcase
		end
		`FPC_OP_EXIT: begin
			nxt_last = 5'd1;
			nxt_addr = addr_ff;
			nxt_data = (step_ff == 5'd0) ? {8'h00, `FPC_D_EXIT1} : {8'h00, `FPC_D_EXIT2};
		end
		`FPC_OP_EXT_EXIT: begin
			nxt_last = 5'd3;
			case (step_ff)
			5'd0: begin nxt_addr = a_first; nxt_data = {8'h00, `FPC_D_UNLOCK1}; end
			5'd1: begin nxt_addr = a_second; nxt_data = {8'h00, `FPC_D_UNLOCK2}; end
			5'd2: begin nxt_addr = a_first; nxt_data = {8'h00, `FPC_D_EXIT1}; end
			default: begin nxt_addr = addr_ff; nxt_data = {8'h00, `FPC_D_EXIT2}; end
			endcase
		end
		`FPC_OP_EXT_PROG: begin
			nxt_last = 5'd3;
			case (step_ff)
			5'd0: begin nxt_addr = a_first; nxt_data = {8'h00, `FPC_D_UNLOCK1}; end
			5'd1: begin nxt_addr = a_second; nxt_data = {8'h00, `FPC_D_UNLOCK2}; end
			5'd2: begin nxt_addr = a_first; nxt_data = {8'h00, `FPC_D_PROG}; end
			default: begin nxt_addr = addr_ff; nxt_data = wdata_ff; end
			endcase
		end
		`FPC_OP_PROG_BIT: begin
			nxt_last = 5'd1;
			nxt_addr = addr_ff;
			nxt_data = (step_ff == 5'd0) ? {8'h00, `FPC_D_PROG} : {15'h0000, wdata_ff[0]};
		end
		`FPC_OP_PW_PROG: begin
			nxt_last = 5'd1; // one portion per command
			nxt_addr = addr_ff;
			nxt_data = (step_ff == 5'd0) ? {8'h00, `FPC_D_PROG} : wdata_ff;
		end
		`FPC_OP_READ_ST, `FPC_OP_RAW_READ: begin
			nxt_read = 1'b1;
			nxt_addr = addr_ff;
		end
		`FPC_OP_RAW_WRITE: begin
			nxt_addr = addr_ff;
			nxt_data = wdata_ff;
		end
		`FPC_OP_CLEAR_ALL: begin
			nxt_last = 5'd1;
			nxt_addr = addr_ff;
			nxt_data = (step_ff == 5'd0) ? {8'h00, `FPC_D_CLR1} : {8'h00, `FPC_D_CLR2};
		end
		`FPC_OP_PW_READ: begin
			nxt_read = 1'b1;
			nxt_last = {1'b0, pw_count} - 5'd1;
			nxt_addr = {19'h00000, step_ff};
		end
		`FPC_OP_PW_UNLOCK: begin
			nxt_last = {1'b0, pw_count} + 5'd2;
			if (step_ff == 5'd0)
				nxt_data = {8'h00, `FPC_D_PW1};
			else if (step_ff == 5'd1)
				nxt_data = {8'h00, `FPC_D_PW2};
			else if (step_ff == nxt_last)
				nxt_data = {8'h00, `FPC_D_PW_END};
			else begin
				nxt_addr = {20'h00000, pidx};
				nxt_data = wide ? pw_ff[{pidx[1:0], 4'h0} +: 16] : {8'h00, pw_ff[{pidx[2:0], 3'h0} +: 8]};
			end
		end
		default: nxt_last = 5'd0;
		endcase
	end
	always @(posedge aclk) begin
		if (!aresetn) begin
			busy_ff <= 1'b0;
			done_flag_ff <= 1'b0;
			refused_ff <= 1'b0;
			step_ff <= 5'd0;
			last_step_ff <= 5'd0;
			waiting_ff <= 1'b0;
			cyc_start_ff <= 1'b0;
			cyc_read_ff <= 1'b0;
			cyc_addr_ff <= 24'h000000;
			cyc_data_ff <= 16'h0000;
			rdata_ff <= 16'h0000;
			pw_rd_ff <= 64'h0000000000000000;
			pw_gap_ff <= 32'h00000000;
		end else begin
			cyc_start_ff <= 1'b0;
			if (pw_wait)
				pw_gap_ff <= pw_gap_ff - 32'h00000001;
			if (start_req) begin
				done_flag_ff <= 1'b0;
				if (op == `FPC_OP_PW_UNLOCK && pw_wait) begin
					refused_ff <= 1'b1;
					done_flag_ff <= 1'b1;
				end else begin
					refused_ff <= 1'b0;
					busy_ff <= 1'b1;
					step_ff <= 5'd0;
				end
			end else if (busy_ff && !waiting_ff) begin
				cyc_start_ff <= 1'b1;
				cyc_read_ff <= nxt_read;
				cyc_addr_ff <= nxt_addr;
				cyc_data_ff <= nxt_data;
				last_step_ff <= nxt_last;
				waiting_ff <= 1'b1;
			end else if (waiting_ff && cyc_done && !cyc_start_ff) begin
				waiting_ff <= 1'b0;
				if (cyc_read_ff) begin
					rdata_ff <= cyc_rdata;
					if (op == `FPC_OP_PW_READ) begin
						if (wide)
							pw_rd_ff[{step_ff[1:0], 4'h0} +: 16] <= cyc_rdata;
						else
							pw_rd_ff[{step_ff[2:0], 3'h0} +: 8] <= cyc_rdata[7:0];
					end
				end
				if (finish) begin
					busy_ff <= 1'b0;
					done_flag_ff <= 1'b1;
					if (op == `FPC_OP_PW_UNLOCK)
						pw_gap_ff <= `FPC_PW_GAP_CYC;
				end else begin
					step_ff <= step_ff + 5'd1;
				end
			end
		end
	end
	fpc_flash_cycle u_cycle (
		.aclk(aclk),
		.aresetn(aresetn),
		.start(cyc_start_ff),
		.is_read(cyc_read_ff),
		.addr(cyc_addr_ff),
		.wdata(cyc_data_ff),
		.dq_in(fl_dq_in),
		.done_ff(cyc_done),
		.rdata_ff(cyc_rdata),
		.fl_addr_ff(fl_addr),
		.dq_out_ff(fl_dq_out),
		.dq_oe_n_ff(fl_dq_oe_n),
		.ce_n_ff(fl_ce_n),
		.oe_n_ff(fl_oe_n),
		.we_n_ff(fl_we_n)
	);
endmodule

// ===== fpc_ctrl_sva.sv
`timescale 1ns/1ps
// ********
// flash strobe and axi answer checks
// ********
module fpc_ctrl_sva (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [23:0] fl_addr,
	input wire logic [15:0] fl_dq_out,
	input wire logic fl_dq_oe_n,
	input wire logic fl_ce_n,
	input wire logic fl_oe_n,
	input wire logic fl_we_n
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	strobe_excl_a: assert property (!(!fl_oe_n && !fl_we_n)) else $error("both strobes low");
	read_float_a: assert property (!fl_oe_n |-> fl_dq_oe_n && !fl_ce_n)
		else $error("dq driven during read");
	write_drive_a: assert property (!fl_we_n |-> !fl_dq_oe_n && !fl_ce_n)
		else $error("write cycle without drive");
	we_width_a: assert property ($fell(fl_we_n) |-> (!fl_we_n)[*8] ##1 fl_we_n)
		else $error("write strobe width");
	oe_width_a: assert property ($fell(fl_oe_n) |-> (!fl_oe_n)[*8] ##1 fl_oe_n)
		else $error("read strobe width");
	wr_stable_a: assert property (!fl_we_n && !$past(fl_we_n) |->
		$stable(fl_dq_out) && $stable(fl_addr)) else $error("write cycle changed");
	dq_gap_a: assert property ($rose(fl_we_n) |-> (!fl_dq_oe_n)[*4])
		else $error("data released early");
	ar_answer_a: assert property (s_axi_arready |=> s_axi_rvalid) else $error("late read data");
	cover property ($fell(fl_we_n));
	cover property ($fell(fl_oe_n));
	cover property (s_axi_bvalid && s_axi_bready);
endmodule
bind fpc_ctrl fpc_ctrl_sva i_sva (.*);

// ===== fpc_flash_model.sv
`timescale 1ns/1ps
// ********
// behavioural device, protection command sets only
// ********
module fpc_flash_model (
	input wire logic wide,
	input wire logic [23:0] fl_addr,
	input wire logic [15:0] fl_dq_out,
	input wire logic fl_ce_n,
	input wire logic fl_oe_n,
	input wire logic fl_we_n,
	output logic [15:0] fl_dq_in
);
	logic [7:0] mode_ff = 8'h00;
	logic [63:0] pw_ff = '1;
	logic [63:0] pin_ff = '0;
	logic [255:0] vol_ff = '1;
	logic [255:0] nvb_ff = '0;
	logic [15:0] rd;
	logic [15:0] last_ff = 16'h0000;
	logic [1:0] step_ff = '0;
	logic [1:0] ul_ff = '0;
	logic [3:0] cnt_ff = '0;
	logic ex_ff = 0;
	logic a0_ff = 0;
	logic cl_ff = 0;
	logic unlocked_ff = 0;
	int tries_ff = 0;
	realtime t_ff = -1.0e5;
	wire [23:0] a1 = wide ? 24'h000555 : 24'h000aaa;
	wire [23:0] a2 = wide ? 24'h0002aa : 24'h000555;
	wire [7:0] d = fl_dq_out[7:0];
	wire [7:0] blk = fl_addr[23:16];
	always @(posedge fl_we_n) begin : take
		logic [1:0] st;
		st = step_ff;
		step_ff = 2'h0;
		if (ex_ff) begin
			ex_ff = 0;
			if (d == 8'h00) mode_ff = 8'h00;
		end else if (a0_ff) begin
			a0_ff = 0;
			if (mode_ff == 8'he0) vol_ff[blk] = d[0];
			if (mode_ff == 8'h60 && wide) pw_ff[16*fl_addr[1:0] +: 16] = fl_dq_out;
			if (mode_ff == 8'h60 && !wide) pw_ff[8*fl_addr[2:0] +: 8] = d;
		end else if (ul_ff == 2'h2) begin
			if (d == 8'h29 && cnt_ff == (wide ? 4'h4 : 4'h8)) begin
				ul_ff = 2'h0;
				tries_ff++;
				// too soon after the last attempt: ignored
				if ($realtime - t_ff >= 6000.0) unlocked_ff = (pin_ff == pw_ff);
				t_ff = $realtime;
			end else begin
				if (wide) pin_ff[16*fl_addr[1:0] +: 16] = fl_dq_out;
				else pin_ff[8*fl_addr[2:0] +: 8] = d;
				cnt_ff++;
			end
		end else if (ul_ff == 2'h1) begin
			ul_ff = (d == 8'h03) ? 2'h2 : 2'h0;
			cnt_ff = 4'h0;
		end else if (cl_ff) begin
			cl_ff = 0;
			if (d == 8'h30 && unlocked_ff) begin
				nvb_ff = '0;
				nvb_ff = '1;
			end
		end else if (d == 8'h90) ex_ff = 1;
		else if (st == 2'h2 && fl_addr == a1 && mode_ff == 8'h00) mode_ff = d;
		else if (st == 2'h1 && d == 8'h55 && fl_addr == a2) step_ff = 2'h2;
		else if (d == 8'haa && fl_addr == a1) step_ff = 2'h1;
		else if (d == 8'ha0) a0_ff = 1;
		else if (d == 8'h25 && mode_ff == 8'h60) ul_ff = 2'h1;
		else if (d == 8'h80) cl_ff = 1;
	end
	always @* begin
		if (mode_ff == 8'h60) rd = wide ? pw_ff[16*fl_addr[1:0] +: 16]
			: {8'h00, pw_ff[8*fl_addr[2:0] +: 8]};
		else if (mode_ff != 8'h00 && blk == 8'h00) rd = 16'h0000;
		// array word outside block 0, with the protection bit on data bit zero
		else if (mode_ff == 8'he0) rd = {fl_addr[15:1], vol_ff[blk]};
		else rd = fl_addr[15:0];
	end
	always @(posedge fl_oe_n) last_ff = rd;
	// a released bus never repeats the last word
	assign fl_dq_in = (!fl_ce_n && !fl_oe_n) ? rd : ~last_ff;
endmodule

// ===== fpc_ctrl_bench.sv
`timescale 1ns/1ps
`include "fpc_defs.vh"
module fpc_ctrl_bench;
	logic aclk = 0;
	logic aresetn = 0;
	logic wide = 0;
	logic [7:0] s_axi_awaddr = '0;
	logic [7:0] s_axi_araddr = '0;
	logic [31:0] s_axi_wdata = '0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 0;
	logic s_axi_wvalid = 0;
	logic s_axi_bready = 1;
	logic s_axi_arvalid = 0;
	logic s_axi_rready = 1;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic [31:0] s_axi_rdata, s;
	logic [23:0] fl_addr;
	logic [15:0] fl_dq_in, fl_dq_out;
	logic fl_dq_oe_n, fl_ce_n, fl_oe_n, fl_we_n;
	int num_errors = 0;
	int comparisons = 0;
	fpc_ctrl i_dut (.*);
	fpc_flash_model i_flash (.*);
	initial forever #2 aclk = ~aclk;
	task automatic test_done;
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: %s got %h", $time, m, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
		end while (!s_axi_bvalid);
		r = s_axi_bresp;
	endtask
	task automatic rd(input logic [7:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 0;
		end while (!s_axi_rvalid);
		s = s_axi_rdata;
		r = s_axi_rresp;
	endtask
	task automatic op(input logic [3:0] o, input logic [7:0] c, input logic [23:0] a,
		input logic [15:0] d);
		int n;
		n = 0;
		wr(`FPC_REG_ADDR, {8'h00, a});
		wr(`FPC_REG_WDATA, {16'h0000, d});
		wr(`FPC_REG_CTRL, {16'h0000, c, o, 2'h0, wide, 1'h1});
		do begin
			rd(`FPC_REG_STATUS);
			n++;
		end while (s[1:0] !== 2'h2 && n < 500);
		if (n >= 500) chk(s, 32'h2, "op hung");
	endtask
	initial begin
		#300000;
		num_errors++;
		$display("unexpected at %0t: watchdog", $time);
		test_done;
	end
	initial begin
		repeat (5) @(posedge aclk);
		aresetn <= 1;
		@(posedge aclk);
		rd(`FPC_REG_PWLO);
		chk(s, 32'hffffffff, "pw reset");
		rd(8'h40);
		chk({30'h0, r}, 32'h2, "unmapped");
		wr(`FPC_REG_STATUS, 32'h0);
		chk({30'h0, r}, 32'h2, "ro write");
		op(`FPC_OP_ENTER, 8'he0, 24'h0, 16'h0);
		chk(i_flash.mode_ff, 32'he0, "entry");
		for (int i = 0; i < 2; i++) begin
			op(`FPC_OP_PROG_BIT, 8'h0, 24'h030000, i[15:0]);
			op(`FPC_OP_READ_ST, 8'h0, 24'h03abcd, 16'h0);
			rd(`FPC_REG_RDATA);
			chk(s[0], i[0], "prot bit");
		end
		op(`FPC_OP_RAW_WRITE, 8'h0, 24'h020000, 16'h00a0);
		op(`FPC_OP_RAW_WRITE, 8'h0, 24'h020000, 16'h0000);
		chk(i_flash.vol_ff[2], 1'h0, "raw write");
		op(`FPC_OP_RAW_READ, 8'h0, 24'h010077, 16'h0);
		rd(`FPC_REG_RDATA);
		chk(s, 32'h77, "block 1");
		op(`FPC_OP_RAW_READ, 8'h0, 24'h000055, 16'h0);
		rd(`FPC_REG_RDATA);
		chk(s, 32'h0, "block 0");
		op(`FPC_OP_EXIT, 8'h0, 24'h123456, 16'h0);
		chk(i_flash.mode_ff, 32'h0, "exit");
		wide <= 1;
		op(`FPC_OP_ENTER, 8'h60, 24'h0, 16'h0);
		for (int k = 3; k >= 0; k--)
			op(`FPC_OP_PW_PROG, 8'h0, k[23:0], 16'h1234 + 16'h1111 * k[15:0]);
		for (int w = 1; w >= 0; w--) begin
			wide <= w[0];
			op(`FPC_OP_PW_READ, 8'h0, 24'h0, 16'h0);
			rd(`FPC_REG_RDATA);
			chk(s, w ? 32'h4567 : 32'h45, "pw last");
			rd(`FPC_REG_PWRLO);
			chk(s, 32'h23451234, "pw lo");
			rd(`FPC_REG_PWRHI);
			chk(s, 32'h45673456, "pw hi");
		end
		op(`FPC_OP_CLEAR_ALL, 8'h0, 24'h0, 16'h0);
		chk(i_flash.nvb_ff[31:0], 32'h0, "clear locked");
		wide <= 1;
		wr(`FPC_REG_PWLO, 32'h0);
		op(`FPC_OP_PW_UNLOCK, 8'h0, 24'h0, 16'h0);
		op(`FPC_OP_PW_UNLOCK, 8'h0, 24'h0, 16'h0);
		chk(s[2], 1'h1, "refused");
		chk({i_flash.unlocked_ff, i_flash.tries_ff[3:0]}, 32'h1, "bad pw");
		repeat (1600) @(posedge aclk);
		wide <= 0;
		wr(`FPC_REG_PWLO, 32'h23451234);
		wr(`FPC_REG_PWHI, 32'h45673456);
		op(`FPC_OP_PW_UNLOCK, 8'h0, 24'h0, 16'h0);
		chk({i_flash.unlocked_ff, i_flash.tries_ff[3:0]}, 32'h12, "unlock");
		op(`FPC_OP_CLEAR_ALL, 8'h0, 24'h0, 16'h0);
		chk(i_flash.nvb_ff[31:0], 32'hffffffff, "cleared");
		op(`FPC_OP_EXIT, 8'h0, 24'h0, 16'h0);
		op(`FPC_OP_ENTER, 8'h88, 24'h0, 16'h0);
		op(`FPC_OP_EXT_PROG, 8'h0, 24'h000010, 16'h00aa);
		chk(i_flash.mode_ff, 32'h88, "ext stays");
		op(`FPC_OP_EXT_EXIT, 8'h0, 24'h0, 16'h0);
		chk(i_flash.mode_ff, 32'h0, "ext exit");
		test_done;
	end
endmodule
